// ---- rtl/irg_pkg.sv ----
// Constants shared by the time code encoder: timing, register map, field layout.
// Assumes a 125 MHz system clock and an APB register bus with 32-bit data.
package irg_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned HALF_MS_NS    = 500000;
  localparam int unsigned HALF_MS_CYC   = HALF_MS_NS / CLK_PERIOD_NS;
  // Times below are counted in 1 ms ticks
  localparam int unsigned SYMBOL_MS     = 10;
  localparam int unsigned PPS_MS        = 200;
  localparam int unsigned EVENT_MS      = 2000;
  localparam int unsigned MARK_MS       = 8;
  localparam int unsigned ONE_MS        = 5;
  localparam int unsigned ZERO_MS       = 2;
  localparam int unsigned LOSS_MS       = 3;
  localparam int unsigned PPS_SYMBOLS   = PPS_MS / SYMBOL_MS;
  localparam logic [3:0]  DIGIT_MAX     = 4'h9;
  // Time limits in BCD
  localparam logic [7:0]  SEC_MAX       = 8'h59;
  localparam logic [7:0]  MIN_MAX       = 8'h59;
  localparam logic [7:0]  HOUR_MAX      = 8'h23;
  localparam logic [11:0] DAY_FIRST     = 12'h001;
  localparam logic [11:0] DAY_LAST      = 12'h365;
  localparam logic [11:0] DAY_LAST_LEAP = 12'h366;
  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  TSET_OFS      = 8'h04;
  localparam logic [7:0]  DSET_OFS      = 8'h08;
  localparam logic [7:0]  TNOW_OFS      = 8'h0C;
  localparam logic [7:0]  STAT_OFS      = 8'h10;
  localparam logic [7:0]  SCFG_OFS      = 8'h14;
  // Control fields
  localparam int unsigned CTRL_SEL_LSB  = 0;
  localparam int unsigned CTRL_INV_BIT  = 2;
  localparam int unsigned CTRL_FMT_LSB  = 3;
  localparam int unsigned CTRL_LEAP_BIT = 5;
  localparam int unsigned CTRL_MSK_LSB  = 8;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0F01;
  // Event period selections
  localparam logic [1:0]  EVT_SEC       = 2'h0;
  localparam logic [1:0]  EVT_MIN       = 2'h1;
  localparam logic [1:0]  EVT_HOUR      = 2'h2;
  // Serial message types
  localparam logic [1:0]  FMT_POS_FIX   = 2'h0;
  localparam logic [1:0]  FMT_GRID      = 2'h1;
  localparam logic [1:0]  FMT_COLON     = 2'h2;
  // Fixed serial setting of the position-fix sentence: baud, data, parity, stop
  localparam logic [31:0] SCFG_POS_FIX  = {8'h00, 2'h1, 2'h0, 4'h8, 16'h12C0};
  localparam logic [31:0] SCFG_RESET    = SCFG_POS_FIX;
  typedef enum logic [1:0] {SYM_ZERO, SYM_ONE, SYM_MARK} irg_sym_e;
endpackage

// ---- rtl/irg_encoder.sv ----
// Time code encoder: frame generator, second/event pulses and signal repeaters.
// Assumes one 125 MHz clock, APB master on the same clock, pins driven from outside.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
// What this block does
// - Second pulse is high for 200 ms at the start of every second.
// - Each event pulse stays active for 2 seconds.
// - Event period selectable: one second, one minute or one hour.
// - One frame per second, frame start aligned with the second pulse.
// - Frame sent as dc level and as 1 kHz amplitude modulated form.
// - Each symbol is a reference mark, a one or a zero.
// - Each symbol lasts 10 ms, ten carrier cycles.
// - Frame holds 100 symbol positions 0 to 99, all transmitted.
// - Reference mark at position 0 and each position ending in nine.
// - BCD seconds, minutes, hours, day sent LSB first at fixed positions.
// - Day of year is 1 on January first and counts up daily.
// - Dc form rising edge marks the symbol's timing instant.
// - Pulse repeater keeps polarity and duration of input pulse.
// - Modulated path shows signal present and drives four outputs.
// - Serial input is copied unchanged onto four outputs.
// - Serial message type selectable: position fix, grid, colon string.
// - Four event outputs with selectable inversion.
// - Grid string made available one second before each minute.
// - Position-fix sentence uses 4800 baud, 8 data, no parity, 1 stop.
module irg_encoder #(
  parameter int unsigned HALF_MS_CYCLES = irg_pkg::HALF_MS_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        pulse_in_i,
  input  wire logic        mod_in_i,
  input  wire logic        serial_in_i,
  output logic             pps_o,
  output logic             dc_code_o,
  output logic             carrier_o,
  output logic             high_amp_o,
  output logic [3:0]       event_o,
  output logic [3:0]       pulse_o,
  output logic [3:0]       mod_o,
  output logic [3:0]       serial_o,
  output logic             signal_present_indicator_o,
  output logic [1:0]       serial_format_o,
  output logic             grid_msg_ready_o
);

  // BCD increment of a two-digit value, wrapping to zero after top
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top);
    logic [7:0] r;
    r = v + 8'h01;
    if (v == top)
      r = 8'h00;
    else if (v[3:0] == irg_pkg::DIGIT_MAX)
      r = {v[7:4] + 4'h1, 4'h0};
    return r;
  endfunction

  function automatic logic [11:0] day_inc(input logic [11:0] v, input logic [11:0] last);
    logic [11:0] r;
    r = v + 12'h001;
    if (v == last)
      r = irg_pkg::DAY_FIRST;
    else if (v[7:0] == {irg_pkg::DIGIT_MAX, irg_pkg::DIGIT_MAX})
      r = {v[11:8] + 4'h1, 8'h00};
    else if (v[3:0] == irg_pkg::DIGIT_MAX)
      r = {v[11:8], v[7:4] + 4'h1, 4'h0};
    return r;
  endfunction

  // ---------------- Register bus ----------------
  logic [31:0] ctrl_r;
  logic [23:0] tset_r;
  logic [11:0] dset_r;
  logic [31:0] scfg_r;
  logic        tload_r;
  logic        dload_r;
  logic        acc;
  logic        wr_en;
  logic        hit;
  logic [31:0] rd_nxt;
  logic        sec_start;
  logic [7:0]  sec_r;
  logic [7:0]  min_r;
  logic [7:0]  hour_r;
  logic [11:0] day_r;
  logic        present_r;
  logic [1:0]  fmt;
  logic [1:0]  evt_sel;
  logic        evt_inv;
  logic [3:0]  evt_msk;

  assign acc     = psel_i && penable_i && !pready_o;
  assign wr_en   = acc && pwrite_i;
  assign fmt     = ctrl_r[irg_pkg::CTRL_FMT_LSB +: 2];
  assign evt_sel = ctrl_r[irg_pkg::CTRL_SEL_LSB +: 2];
  assign evt_inv = ctrl_r[irg_pkg::CTRL_INV_BIT];
  assign evt_msk = ctrl_r[irg_pkg::CTRL_MSK_LSB +: 4];

  always_comb
  begin
    hit    = 1'b1;
    rd_nxt = 32'h0000_0000;
    case (paddr_i)
      irg_pkg::CTRL_OFS: rd_nxt = ctrl_r;
      irg_pkg::TSET_OFS: rd_nxt = {8'h00, tset_r};
      irg_pkg::DSET_OFS: rd_nxt = {20'h00000, dset_r};
      irg_pkg::TNOW_OFS: rd_nxt = {8'h00, hour_r, min_r, sec_r};
      irg_pkg::STAT_OFS: rd_nxt = {19'h00000, present_r, day_r};
      // Position-fix sentence forces its fixed line setting
      irg_pkg::SCFG_OFS: rd_nxt = (fmt == irg_pkg::FMT_POS_FIX) ? irg_pkg::SCFG_POS_FIX : scfg_r;
      default:           hit    = 1'b0;
    endcase
  end

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end
    else
    begin
      pready_o  <= acc;
      pslverr_o <= acc && !hit;
      if (acc && !pwrite_i)
        prdata_o <= rd_nxt;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_r <= irg_pkg::CTRL_RESET;
      tset_r <= 24'h000000;
      dset_r <= irg_pkg::DAY_FIRST;
      scfg_r <= irg_pkg::SCFG_RESET;
    end
    else if (wr_en)
    begin
      case (paddr_i)
        irg_pkg::CTRL_OFS: ctrl_r <= pwdata_i;
        irg_pkg::TSET_OFS: tset_r <= pwdata_i[23:0];
        irg_pkg::DSET_OFS: dset_r <= pwdata_i[11:0];
        irg_pkg::SCFG_OFS: scfg_r <= pwdata_i;
        default:           ctrl_r <= ctrl_r;
      endcase
    end
  end

  // Pending loads apply at the next second; a write in the same cycle wins
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tload_r <= 1'b0;
      dload_r <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr_i == irg_pkg::TSET_OFS)
        tload_r <= 1'b1;
      else if (sec_start)
        tload_r <= 1'b0;
      if (wr_en && paddr_i == irg_pkg::DSET_OFS)
        dload_r <= 1'b1;
      else if (sec_start)
        dload_r <= 1'b0;
    end
  end

  // ---------------- Timebase ----------------
  logic [16:0] half_cnt_r;
  logic        half_tick;
  logic        ms_half_r;
  logic        ms_tick;
  logic [3:0]  sym_ms_r;
  logic [3:0]  pos_u_r;
  logic [3:0]  pos_t_r;

  assign half_tick = (half_cnt_r == 17'(HALF_MS_CYCLES - 1));
  assign ms_tick   = half_tick && ms_half_r;
  assign sec_start = ms_tick && sym_ms_r == 4'(irg_pkg::SYMBOL_MS - 1)
                     && pos_u_r == irg_pkg::DIGIT_MAX && pos_t_r == irg_pkg::DIGIT_MAX;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      half_cnt_r <= 17'h00000;
      ms_half_r  <= 1'b0;
    end
    else
    begin
      half_cnt_r <= half_tick ? 17'h00000 : half_cnt_r + 17'h00001;
      if (half_tick)
        ms_half_r <= !ms_half_r;
    end
  end

  // Ten ms per symbol, positions 0..99 per second
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sym_ms_r <= 4'h0;
      pos_u_r  <= 4'h0;
      pos_t_r  <= 4'h0;
    end
    else if (ms_tick)
    begin
      if (sym_ms_r == 4'(irg_pkg::SYMBOL_MS - 1))
      begin
        sym_ms_r <= 4'h0;
        pos_u_r  <= (pos_u_r == irg_pkg::DIGIT_MAX) ? 4'h0 : pos_u_r + 4'h1;
        if (pos_u_r == irg_pkg::DIGIT_MAX)
          pos_t_r <= (pos_t_r == irg_pkg::DIGIT_MAX) ? 4'h0 : pos_t_r + 4'h1;
      end
      else
        sym_ms_r <= sym_ms_r + 4'h1;
    end
  end

  // ---------------- Time of day ----------------
  logic [7:0]  sec_nxt;
  logic [7:0]  min_nxt;
  logic [7:0]  hour_nxt;
  logic [11:0] day_nxt;

  always_comb
  begin
    sec_nxt  = bcd_inc(sec_r, irg_pkg::SEC_MAX);
    min_nxt  = min_r;
    hour_nxt = hour_r;
    day_nxt  = day_r;
    if (sec_r == irg_pkg::SEC_MAX)
    begin
      min_nxt = bcd_inc(min_r, irg_pkg::MIN_MAX);
      if (min_r == irg_pkg::MIN_MAX)
      begin
        hour_nxt = bcd_inc(hour_r, irg_pkg::HOUR_MAX);
        if (hour_r == irg_pkg::HOUR_MAX)
          day_nxt = day_inc(day_r, ctrl_r[irg_pkg::CTRL_LEAP_BIT] ?
                            irg_pkg::DAY_LAST_LEAP : irg_pkg::DAY_LAST);
      end
    end
    if (tload_r)
      {hour_nxt, min_nxt, sec_nxt} = tset_r;
    if (dload_r)
      day_nxt = dset_r;
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sec_r  <= 8'h00;
      min_r  <= 8'h00;
      hour_r <= 8'h00;
      day_r  <= irg_pkg::DAY_FIRST;
    end
    else if (sec_start)
    begin
      sec_r  <= sec_nxt;
      min_r  <= min_nxt;
      hour_r <= hour_nxt;
      day_r  <= day_nxt;
    end
  end

  // ---------------- Symbol encoding ----------------
  logic [8:0]       grp_bits;
  irg_pkg::irg_sym_e sym;
  logic [3:0]       hi_ms;

  // Field bits of the current ten-position group, LSB first
  always_comb
  begin
    case (pos_t_r)
      4'h0:    grp_bits = {sec_r[6:4], 1'b0, sec_r[3:0], 1'b0};
      4'h1:    grp_bits = {1'b0, min_r[6:4], 1'b0, min_r[3:0]};
      4'h2:    grp_bits = {2'b00, hour_r[5:4], 1'b0, hour_r[3:0]};
      4'h3:    grp_bits = {day_r[7:4], 1'b0, day_r[3:0]};
      4'h4:    grp_bits = {7'h00, day_r[9:8]};
      default: grp_bits = 9'h000;
    endcase
    if (pos_u_r == irg_pkg::DIGIT_MAX || (pos_u_r == 4'h0 && pos_t_r == 4'h0))
      sym = irg_pkg::SYM_MARK;
    else if (grp_bits[pos_u_r])
      sym = irg_pkg::SYM_ONE;
    else
      sym = irg_pkg::SYM_ZERO;
    case (sym)
      irg_pkg::SYM_MARK: hi_ms = 4'(irg_pkg::MARK_MS);
      irg_pkg::SYM_ONE:  hi_ms = 4'(irg_pkg::ONE_MS);
      default:           hi_ms = 4'(irg_pkg::ZERO_MS);
    endcase
  end

  // Both forms share the symbol start; high part leads the symbol
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dc_code_o  <= 1'b0;
      high_amp_o <= 1'b0;
      carrier_o  <= 1'b0;
      pps_o      <= 1'b0;
    end
    else
    begin
      dc_code_o  <= sym_ms_r < hi_ms;
      high_amp_o <= sym_ms_r < hi_ms;
      carrier_o  <= ms_half_r;
      pps_o      <= pos_t_r < 4'(irg_pkg::PPS_SYMBOLS / 10) ;
    end
  end

  // ---------------- Event pulses ----------------
  logic [10:0] evt_cnt_r;
  logic        evt_fire;

  assign evt_fire = sec_start && (evt_sel == irg_pkg::EVT_SEC
                    || (evt_sel == irg_pkg::EVT_MIN && sec_nxt == 8'h00)
                    || (evt_sel == irg_pkg::EVT_HOUR && sec_nxt == 8'h00
                        && min_nxt == 8'h00));

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      evt_cnt_r <= 11'h000;
    else if (evt_fire)
      evt_cnt_r <= 11'(irg_pkg::EVENT_MS);
    else if (ms_tick && evt_cnt_r != 11'h000)
      evt_cnt_r <= evt_cnt_r - 11'h001;
  end

  // ---------------- Repeaters ----------------
  logic [2:0] pulse_sync_r;
  logic [2:0] mod_sync_r;
  logic [1:0] ser_sync_r;
  logic [1:0] loss_cnt_r;
  logic       mod_edge;

  assign mod_edge = mod_sync_r[1] != mod_sync_r[2];

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pulse_sync_r <= 3'h0;
      mod_sync_r   <= 3'h0;
      ser_sync_r   <= 2'h3;
      loss_cnt_r   <= 2'h0;
      present_r    <= 1'b0;
    end
    else
    begin
      pulse_sync_r <= {pulse_sync_r[1:0], pulse_in_i};
      mod_sync_r   <= {mod_sync_r[1:0], mod_in_i};
      ser_sync_r   <= {ser_sync_r[0], serial_in_i};
      if (mod_edge)
        loss_cnt_r <= 2'(irg_pkg::LOSS_MS);
      else if (ms_tick && loss_cnt_r != 2'h0)
        loss_cnt_r <= loss_cnt_r - 2'h1;
      present_r <= loss_cnt_r != 2'h0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_out
      always_ff @(posedge clock_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          event_o[gi]  <= 1'b0;
          pulse_o[gi]  <= 1'b0;
          mod_o[gi]    <= 1'b0;
          serial_o[gi] <= 1'b1;
        end
        else
        begin
          event_o[gi]  <= (evt_msk[gi] && evt_cnt_r != 11'h000) ^ evt_inv;
          pulse_o[gi]  <= pulse_sync_r[2];
          mod_o[gi]    <= mod_sync_r[2];
          serial_o[gi] <= ser_sync_r[1];
        end
      end
    end
  endgenerate

  // Message type and minute-ahead availability of the grid string
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      serial_format_o            <= irg_pkg::FMT_POS_FIX;
      grid_msg_ready_o           <= 1'b0;
      signal_present_indicator_o <= 1'b0;
    end
    else
    begin
      serial_format_o            <= fmt;
      grid_msg_ready_o           <= sec_start && fmt == irg_pkg::FMT_GRID
                                    && sec_nxt == irg_pkg::SEC_MAX;
      signal_present_indicator_o <= present_r;
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_pps_start:   assert property (sec_start |=> ##1 pps_o)
    else $error("pps not high at second start");
  a_pps_end:     assert property ($fell(pps_o)
                                  |-> $past(pos_t_r) == 4'h2 && $past(sym_ms_r) == 4'h0)
    else $error("pps width wrong");
  a_evt_load:    assert property (evt_fire |=> evt_cnt_r == 11'(irg_pkg::EVENT_MS))
    else $error("event width not loaded");
  a_evt_minute:  assert property (sec_start && evt_sel == irg_pkg::EVT_MIN && sec_nxt != 8'h00
                                  |-> !evt_fire)
    else $error("minute event off boundary");
  a_frame_align: assert property (sec_start |=> pos_t_r == 4'h0 && pos_u_r == 4'h0)
    else $error("frame not aligned");
  a_mark_pos:    assert property (pos_u_r == 4'h9 |-> sym == irg_pkg::SYM_MARK)
    else $error("missing reference mark");
  a_sec_bit:     assert property (pos_t_r == 4'h0 && pos_u_r == 4'h1
                                  |-> (sym == irg_pkg::SYM_ONE) == sec_r[0])
    else $error("seconds bit wrong");
  a_day_range:   assert property (day_r != 12'h000)
    else $error("day zero");
  a_dc_rise:     assert property ($rose(dc_code_o) |-> $past(sym_ms_r) == 4'h0)
    else $error("dc edge off time");
  a_pulse_copy:  assert property (pulse_o[0] == $past(pulse_sync_r[2]))
    else $error("pulse not copied");
  a_present:     assert property (mod_edge |=> ##2 signal_present_indicator_o)
    else $error("signal present missing");
  a_mark_width:  assert property (sym == irg_pkg::SYM_MARK && sym_ms_r == 4'h7
                                  |=> dc_code_o)
    else $error("mark too short");

  c_sec:    cover property (sec_start);
  c_evt:    cover property (evt_fire && evt_sel == irg_pkg::EVT_MIN);
  c_grid:   cover property (grid_msg_ready_o);
  c_signal: cover property ($fell(signal_present_indicator_o));

endmodule

// ---- dv/irg_code_receiver.sv ----
// Time code receiver model: classifies each dc level-shift pulse by its width.
// Assumes the code line is sampled on the encoder's own clock.
`timescale 1ns/1ps
module irg_code_receiver #(
  parameter int unsigned HALF_MS_CYCLES = 5
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        code_i,
  output logic             sym_valid_o,
  output logic [1:0]       sym_o,
  output logic [15:0]      period_o
);
  localparam int unsigned MS = 2 * HALF_MS_CYCLES;
  logic        prev_r;
  logic [15:0] high_r;
  logic [15:0] gap_r;
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prev_r      <= 1'b0;
      high_r      <= 16'h0000;
      gap_r       <= 16'h0000;
      sym_valid_o <= 1'b0;
      sym_o       <= 2'h0;
      period_o    <= 16'h0000;
    end
    else
    begin
      prev_r      <= code_i;
      sym_valid_o <= prev_r & ~code_i;
      gap_r       <= (code_i & ~prev_r) ? 16'h0001 : gap_r + 16'h0001;
      high_r      <= (code_i & ~prev_r) ? 16'h0001 : high_r + {15'h0000, code_i};
      if (code_i & ~prev_r)
        period_o <= gap_r;
      // Unknown widths are reported as 3 so the bench sees them
      if (prev_r & ~code_i)
        sym_o <= (high_r == 16'(8 * MS)) ? irg_pkg::SYM_MARK
               : (high_r == 16'(5 * MS)) ? irg_pkg::SYM_ONE
               : (high_r == 16'(2 * MS)) ? irg_pkg::SYM_ZERO : 2'h3;
    end
  end
endmodule

// ---- dv/irig_b_time_code_encoder_tb_top.sv ----
// Testbench of the time code encoder: registers, repeaters, frames, pulses.
// Assumes the receiver model beside it and a shortened millisecond count.
`timescale 1ns/1ps
module irig_b_time_code_encoder_tb_top;
  localparam int H  = 5;
  localparam int MS = 2 * H;
  logic        clock_i;
  logic        rst_n_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        pulse_in_i;
  logic        mod_in_i;
  logic        serial_in_i;
  logic        pps_o;
  logic        dc_code_o;
  logic        carrier_o;
  logic        high_amp_o;
  logic [3:0]  event_o;
  logic [3:0]  pulse_o;
  logic [3:0]  mod_o;
  logic [3:0]  serial_o;
  logic        signal_present_indicator_o;
  logic [1:0]  serial_format_o;
  logic        grid_msg_ready_o;
  logic        sym_valid;
  logic [1:0]  sym;
  logic [15:0] period;
  logic [33:0] e;
  logic [3:0]  rv;
  logic        pps_d = 1'b0;
  logic        car_d = 1'b0;
  logic [31:0] rnd   = 32'h0000_0008;
  int          n_fail = 0;
  int          comparisons = 0;
  int          sec_idx = 0;
  int          since_pps = 0;
  int          pps_run = 0;
  // First counted edge after release still shows the reset level
  int          car_run = -2;
  int          npos = 0;
  int          grid_cnt = 0;
  int          run[3] = '{0, 0, 0};
  logic [1:0]  sym_q[$];
  logic [33:0] rd_q[$];
  int          wq[3][$];
  logic [35:0] ft[8] = '{36'h000000001, 36'h000001001, 36'h235958366, 36'h235959366,
                         36'h000000001, 36'h000001001, 36'h000002001, 36'h000003001};

  irg_encoder #(.HALF_MS_CYCLES(H)) i_irg_encoder (
    .clock_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .pulse_in_i, .mod_in_i, .serial_in_i,
    .pps_o, .dc_code_o, .carrier_o, .high_amp_o, .event_o, .pulse_o, .mod_o,
    .serial_o, .signal_present_indicator_o, .serial_format_o, .grid_msg_ready_o);
  irg_code_receiver #(.HALF_MS_CYCLES(H)) i_irg_code_receiver (
    .clock_i, .rst_n_i, .code_i(dc_code_o), .sym_valid_o(sym_valid), .sym_o(sym),
    .period_o(period));

  function automatic logic [31:0] xs();
    rnd = rnd ^ (rnd << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
    return rnd;
  endfunction
  function automatic bit bad(input logic [31:0] a, input logic [31:0] b);
    comparisons++;
    return a !== b;
  endfunction
  function automatic logic [1:0] exp_sym(input int p, input logic [23:0] t,
                                         input logic [11:0] d);
    logic [7:0] v;
    int         i;
    v = p < 10 ? t[7:0] : p < 20 ? t[15:8] : p < 30 ? t[23:16]
      : p < 40 ? d[7:0] : p < 50 ? {4'h0, d[11:8]} : 8'h00;
    i = p % 10 - int'(p < 10);
    if (p == 0 || p % 10 == 9)
      return irg_pkg::SYM_MARK;
    return (i < 4 ? v[i] : i > 4 ? v[i - 1] : 1'b0) ? irg_pkg::SYM_ONE : irg_pkg::SYM_ZERO;
  endfunction
  task automatic err(input string m);
    n_fail++;
    $display("ERROR t=%0t %s", $time, m);
  endtask
  task automatic results();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] ex, input logic er);
    rd_q.push_back({~w, er, ex});
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= wd;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do
      @(posedge clock_i);
    while (pready_o !== 1'b1);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask
  // Channel 0 pulse repeater, 1 serial (active low), 2 modulated
  task automatic drive(input int c, input int w);
    wq[c].push_back(w);
    if (c == 0)
      pulse_in_i <= 1'b1;
    else if (c == 1)
      serial_in_i <= 1'b0;
    else
      mod_in_i <= 1'b1;
    repeat (w) @(posedge clock_i);
    pulse_in_i  <= 1'b0;
    serial_in_i <= 1'b1;
    mod_in_i    <= 1'b0;
    repeat (w) @(posedge clock_i);
  endtask
  task automatic at(input int s, input int ms);
    wait (sec_idx == s + 1);
    repeat (ms * MS) @(posedge clock_i);
  endtask

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
    if (rst_n_i && psel_i && penable_i && pready_o === 1'b1)
    begin
      e = rd_q.pop_front();
      if (bad(pslverr_o, e[32]) || e[33] && bad(prdata_o, e[31:0]))
        err("bus answer differs");
    end

  always @(posedge clock_i)
    if (rst_n_i && sym_valid === 1'b1)
    begin
      if (bad(sym, sym_q.pop_front()))
        err("symbol differs");
      if (npos > 0 && bad(period, 10 * MS))
        err("symbol spacing differs");
      if (npos % 100 == 0 && (since_pps < 76 || since_pps > 86))
        err("frame not aligned with second pulse");
      npos++;
    end

  always @(posedge clock_i)
    if (rst_n_i)
    begin
      since_pps++;
      car_run++;
      pps_run += pps_o;
      if (grid_msg_ready_o === 1'b1)
        grid_cnt++;
      if (bad(high_amp_o, dc_code_o))
        err("amplitude select differs from dc code");
      if (pps_o && !pps_d)
      begin
        sec_idx++;
        if (sec_idx > 1 && bad(since_pps, 1000 * MS))
          err("second spacing differs");
        since_pps = 0;
      end
      if (!pps_o && pps_d && bad(pps_run, 200 * MS))
        err("second pulse width differs");
      if (!pps_o)
        pps_run = 0;
      if (carrier_o !== car_d)
      begin
        if (car_run > 0 && bad(car_run, H))
          err("carrier half period differs");
        car_run = 0;
      end
      pps_d = pps_o;
      car_d = carrier_o;
      for (int c = 0; c < 3; c++)
      begin
        rv = c == 0 ? pulse_o : c == 1 ? ~serial_o : mod_o;
        if (rv !== {4{rv[0]}})
          err("repeater outputs disagree");
        if (rv[0])
          run[c]++;
        else if (run[c] > 0)
        begin
          if (bad(run[c], wq[c].pop_front()))
            err("repeated pulse width differs");
          run[c] = 0;
        end
      end
    end

  initial
  begin
    rst_n_i     = 1'b0;
    psel_i      = 1'b0;
    penable_i   = 1'b0;
    pwrite_i    = 1'b0;
    paddr_i     = 8'h00;
    pwdata_i    = 32'h0000_0000;
    pulse_in_i  = 1'b0;
    mod_in_i    = 1'b0;
    serial_in_i = 1'b1;
    for (int k = 0; k < 8; k++)
      for (int p = 0; p < 100; p++)
        sym_q.push_back(exp_sym(p, ft[k][35:12], ft[k][11:0]));
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    apb(0, irg_pkg::CTRL_OFS, 0, irg_pkg::CTRL_RESET, 0);
    apb(0, 8'h18, 0, 0, 1);
    apb(1, 8'h18, 32'hFFFF_FFFF, 0, 1);
    for (int f = 0; f < 3; f++)
    begin
      apb(1, irg_pkg::CTRL_OFS, 32'h0F01 | (f << 3), 0, 0);
      @(posedge clock_i);
      if (bad(serial_format_o, f))
        err("message type differs");
      if (f == 0)
        apb(0, irg_pkg::SCFG_OFS, 0, irg_pkg::SCFG_POS_FIX, 0);
    end
    $display("test registers finished");
    for (int k = 0; k < 18; k++)
      drive(k % 3, 3 + xs() % 40);
    for (int k = 0; k < 12; k++)
      drive(2, MS);
    if (bad(signal_present_indicator_o, 1))
      err("signal present not shown");
    repeat (5 * MS) @(posedge clock_i);
    if (bad(signal_present_indicator_o, 0))
      err("signal present not cleared");
    $display("test repeaters finished");
    at(1, 0);
    // Hour events, grid format, leap year: day 366 must wrap to 001
    apb(1, irg_pkg::CTRL_OFS, 32'h0F2A, 0, 0);
    apb(1, irg_pkg::TSET_OFS, 32'h0023_5958, 0, 0);
    apb(1, irg_pkg::DSET_OFS, 32'h0000_0366, 0, 0);
    at(3, 10);
    if (bad(event_o, 4'h0))
      err("event fired off its period");
    apb(0, irg_pkg::TNOW_OFS, 0, 32'h0023_5959, 0);
    apb(0, irg_pkg::STAT_OFS, 0, 32'h0000_0366, 0);
    at(4, 10);
    if (bad(event_o, 4'hF))
      err("hour event missing");
    apb(0, irg_pkg::STAT_OFS, 0, 32'h0000_0001, 0);
    at(5, 980);
    if (bad(event_o, 4'hF))
      err("event ended early");
    at(6, 10);
    if (bad(event_o, 4'h0))
      err("event too long");
    apb(1, irg_pkg::CTRL_OFS, 32'h0F0E, 0, 0);
    repeat (2) @(posedge clock_i);
    if (bad(event_o, 4'hF))
      err("inversion not applied");
    apb(1, irg_pkg::CTRL_OFS, 32'h0508, 0, 0);
    at(7, 10);
    if (bad(event_o, 4'h5))
      err("second event missing");
    if (bad(grid_cnt, 1))
      err("grid message ready count differs");
    $display("test time code finished");
    results();
  end

  initial
  begin
    repeat (92000) @(posedge clock_i);
    err("timeout");
    results();
  end
endmodule
